//--- tod_defs.vh
// Register map, field positions, reset values and timing counts of the time-of-day block
`ifndef TOD_DEFS_VH
`define TOD_DEFS_VH

// Byte addresses of the 32-bit registers
`define TOD_ADDR_CTRL        32'h10001004
`define TOD_ADDR_SECONDS     32'h10001008
`define TOD_ADDR_FRACTION    32'h1000100C
`define TOD_ADDR_FRAC_ALARM  32'h10001010
`define TOD_ADDR_INT_STATUS  32'h10001014
`define TOD_ADDR_INT_MASK    32'h10001018

// Control/status fields
`define TOD_CTRL_FLAG_BIT    0
`define TOD_CTRL_IRQEN_BIT   1
`define TOD_CTRL_ON_BIT      2
`define TOD_CTRL_ON_RST      1'h0
`define TOD_CTRL_IRQEN_RST   1'h0
`define TOD_CTRL_FLAG_RST    1'h0

// Interrupt status and mask fields
`define TOD_INT_TICK_BIT     0
`define TOD_INT_ALARM_BIT    1
`define TOD_INT_WIDTH        2
`define TOD_INT_STATUS_RST   2'h0
`define TOD_INT_MASK_RST     2'h0

// Fraction counter: reference divided by 128 gives 256 Hz into eight bits
`define TOD_REF_HZ           32768
`define TOD_PRESCALE         128
`define TOD_PRESCALE_W       7
`define TOD_FRAC_W           8
`define TOD_FRAC_HZ          (`TOD_REF_HZ / `TOD_PRESCALE)
`define TOD_FRAC_ALL_ONES    8'hFF

`define TOD_DATA_W           32
`define TOD_ADDR_W           32
`define TOD_RD_IDLE          32'h00000000

`endif

//--- tod_ref_sync.v
// Two-flop synchroniser for the slow reference clock pin with rising-edge pulse
`timescale 1ns/1ps
`include "tod_defs.vh"

module tod_ref_sync
(
    input  wire sys_clk,
    input  wire rstn,
    input  wire ce,
    input  wire ref_pin,
    output reg  ref_rise
);

    reg meta_reg;
    reg sync_reg;
    reg last_reg;

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
            ref_rise <= 1'b0;
        end
        else if (ce)
        begin
            meta_reg <= ref_pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
            ref_rise <= sync_reg & ~last_reg;
        end
    end

endmodule

//--- tod_frac_cnt.v
// Prescaler and eight-bit fraction-of-second counter with one-second carry
`timescale 1ns/1ps
`include "tod_defs.vh"

module tod_frac_cnt
#(
    parameter PRESCALE_W = `TOD_PRESCALE_W,
    parameter FRAC_W     = `TOD_FRAC_W
)
(
    input  wire              sys_clk,
    input  wire              ce,
    input  wire              ref_rise,
    input  wire              clear,
    input  wire              set_all,
    output reg  [FRAC_W-1:0] frac,
    output reg               carry
);

    reg [PRESCALE_W-1:0] pre_reg;

    // No reset at all: the count survives every reset but power-on, where it is undefined
    always @(posedge sys_clk)
    begin
        if (ce)
        begin
            carry <= 1'b0;
            if (clear)
            begin
                pre_reg <= {PRESCALE_W{1'b0}};
                frac    <= {FRAC_W{1'b0}};
            end
            else if (set_all)
            begin
                frac <= {FRAC_W{1'b1}};
            end
            else if (ref_rise)
            begin
                pre_reg <= pre_reg + {{(PRESCALE_W-1){1'b0}}, 1'b1};
                if (&pre_reg)
                begin
                    frac  <= frac + {{(FRAC_W-1){1'b0}}, 1'b1}; // R11
                    carry <= &frac;                             // R11
                end
            end
        end
    end

endmodule

//--- tod_top.v
// Time-of-day seconds counter, fraction snapshot and alarm control/status registers
// Operation
// R1: alarm_on at 0 turns the alarm function off; at 1 turns it on.
// R2: alarm_irq_enable at 0 blocks alarm_flag from the processor; 1 lets it interrupt. Only alarm_irq is gated; alarm events still reach irq.
// R3: alarm_flag is read-only, 1 while alarm pending; any fraction_alarm_reg write clears it.
// R4: Software uses only full 32-bit loads and stores on these registers.
// R5: seconds_count_reg is 32-bit read/write, incremented on each one-second carry.
// R6: Each seconds read copies the fraction counter into a holding buffer.
// R7: Writing seconds loads the value and clears the fraction counter to zero.
// R8: Seconds count survives watchdog and external-pin resets; only power-on disturbs it.
// R9: After power-on the seconds count is undefined; software must write it first.
// R10: Fraction reads return the holding buffer until seconds is read again.
// R11: Eight-bit fraction counter runs at reference divided by 128; overflow is the carry.
// R12: Alarm interrupt line is alarm_flag AND alarm_irq_enable.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "tod_defs.vh"

module tod_top
#(
    parameter DATA_W = `TOD_DATA_W,
    parameter ADDR_W = `TOD_ADDR_W,
    parameter FRAC_W = `TOD_FRAC_W
)
(
    input  wire              sys_clk,
    input  wire              rstn,
    input  wire              ce,
    input  wire [ADDR_W-1:0] addr,
    input  wire [DATA_W-1:0] wr_data,
    input  wire              wr_en,
    input  wire              rd_en,
    output reg  [DATA_W-1:0] rd_data,
    input  wire              slow_reference_clock,
    input  wire              alarm_match,
    output reg               alarm_active,
    output reg               alarm_irq,
    output reg               irq
);

    // Exact word match; byte-lane accesses are not supported by this port
    function hit;
        input [ADDR_W-1:0] a;
        input [ADDR_W-1:0] base;
        begin
            hit = (a == base); // R4
        end
    endfunction

    wire sel_ctrl;
    wire sel_sec;
    wire sel_frac;
    wire sel_falarm;
    wire sel_ists;
    wire sel_imask;

    assign sel_ctrl   = hit(addr, `TOD_ADDR_CTRL);
    assign sel_sec    = hit(addr, `TOD_ADDR_SECONDS);
    assign sel_frac   = hit(addr, `TOD_ADDR_FRACTION);
    assign sel_falarm = hit(addr, `TOD_ADDR_FRAC_ALARM);
    assign sel_ists   = hit(addr, `TOD_ADDR_INT_STATUS);
    assign sel_imask  = hit(addr, `TOD_ADDR_INT_MASK);

    wire wr_ctrl;
    wire wr_sec;
    wire wr_frac;
    wire wr_falarm;
    wire wr_ists;
    wire wr_imask;
    wire rd_sec;

    assign wr_ctrl   = ce & wr_en & sel_ctrl;
    assign wr_sec    = ce & wr_en & sel_sec;
    assign wr_frac   = ce & wr_en & sel_frac;
    assign wr_falarm = ce & wr_en & sel_falarm;
    assign wr_ists   = ce & wr_en & sel_ists;
    assign wr_imask  = ce & wr_en & sel_imask;
    assign rd_sec    = ce & rd_en & sel_sec;

    reg               on_reg;
    reg               irqen_reg;
    reg               flag_reg;
    reg               flag_next;
    reg [DATA_W-1:0]  seconds_reg;
    reg [DATA_W-1:0]  seconds_next;
    reg [FRAC_W-1:0]  hold_reg;
    reg [`TOD_INT_WIDTH-1:0] ists_reg;
    reg [`TOD_INT_WIDTH-1:0] ists_next;
    reg [`TOD_INT_WIDTH-1:0] imask_reg;
    reg [DATA_W-1:0]  rd_next;
    reg               flag_rise_reg;

    wire              ref_rise;
    wire [FRAC_W-1:0] frac;
    wire              carry;

    tod_ref_sync u_sync
    (
        .sys_clk  (sys_clk),
        .rstn     (rstn),
        .ce       (ce),
        .ref_pin  (slow_reference_clock),
        .ref_rise (ref_rise)
    );

    tod_frac_cnt
    #(
        .PRESCALE_W (`TOD_PRESCALE_W),
        .FRAC_W     (FRAC_W)
    )
    u_frac
    (
        .sys_clk  (sys_clk),
        .ce       (ce),
        .ref_rise (ref_rise),
        .clear    (wr_sec),
        .set_all  (wr_frac),
        .frac     (frac),
        .carry    (carry)
    );

    // Alarm control bits
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            on_reg    <= `TOD_CTRL_ON_RST;
            irqen_reg <= `TOD_CTRL_IRQEN_RST;
        end
        else if (wr_ctrl)
        begin
            on_reg    <= wr_data[`TOD_CTRL_ON_BIT];    // R1
            irqen_reg <= wr_data[`TOD_CTRL_IRQEN_BIT]; // R2
        end
    end

    // A match in the same cycle as the clearing write still sets the flag
    always @*
    begin
        flag_next = flag_reg;
        if (wr_falarm)
        begin
            flag_next = 1'b0; // R3
        end
        if (on_reg & alarm_match)
        begin
            flag_next = 1'b1; // R1
        end
    end

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            flag_reg      <= `TOD_CTRL_FLAG_RST;
            flag_rise_reg <= 1'b0;
        end
        else if (ce)
        begin
            flag_reg      <= flag_next;
            flag_rise_reg <= flag_next & ~flag_reg;
        end
    end

    // Seconds count: deliberately outside rstn, so watchdog and pin resets keep it
    always @*
    begin
        seconds_next = seconds_reg;
        if (wr_sec)
        begin
            seconds_next = wr_data; // R7
        end
        else if (carry)
        begin
            seconds_next = seconds_reg + {{(DATA_W-1){1'b0}}, 1'b1}; // R5
        end
    end

    always @(posedge sys_clk)
    begin
        if (ce)
        begin
            seconds_reg <= seconds_next; // R8 R9
        end
    end

    // Snapshot keeps seconds and fraction coherent across a rollover except while carry is high: old seconds with fraction 0
    always @(posedge sys_clk)
    begin
        if (rd_sec)
        begin
            hold_reg <= frac; // R6
        end
    end

    // Sticky event bits, write one to clear, a new event wins over the clear
    always @*
    begin
        ists_next = ists_reg;
        if (wr_ists)
        begin
            ists_next = ists_reg & ~wr_data[`TOD_INT_WIDTH-1:0];
        end
        if (carry)
        begin
            ists_next[`TOD_INT_TICK_BIT] = 1'b1;
        end
        if (flag_rise_reg)
        begin
            ists_next[`TOD_INT_ALARM_BIT] = 1'b1;
        end
    end

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            ists_reg  <= `TOD_INT_STATUS_RST;
            imask_reg <= `TOD_INT_MASK_RST;
        end
        else if (ce)
        begin
            ists_reg <= ists_next;
            if (wr_imask)
            begin
                imask_reg <= wr_data[`TOD_INT_WIDTH-1:0];
            end
        end
    end

    // Read mux; unmapped addresses and the alarm compare register read as zero
    always @*
    begin
        rd_next = `TOD_RD_IDLE;
        if (sel_ctrl)
        begin
            rd_next[`TOD_CTRL_ON_BIT]    = on_reg;
            rd_next[`TOD_CTRL_IRQEN_BIT] = irqen_reg;
            rd_next[`TOD_CTRL_FLAG_BIT]  = flag_reg; // R3
        end
        else if (sel_sec)
        begin
            rd_next = seconds_reg; // R5
        end
        else if (sel_frac)
        begin
            rd_next[FRAC_W-1:0] = hold_reg; // R10
        end
        else if (sel_ists)
        begin
            rd_next[`TOD_INT_WIDTH-1:0] = ists_reg;
        end
        else if (sel_imask)
        begin
            rd_next[`TOD_INT_WIDTH-1:0] = imask_reg;
        end
    end

    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            rd_data <= `TOD_RD_IDLE;
        end
        else if (ce)
        begin
            if (rd_en)
            begin
                rd_data <= rd_next;
            end
            else
            begin
                rd_data <= `TOD_RD_IDLE;
            end
        end
    end

    // Outputs from flops; they follow their cause by one cycle
    always @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            alarm_active <= 1'b0;
            alarm_irq    <= 1'b0;
            irq          <= 1'b0;
        end
        else if (ce)
        begin
            alarm_active <= on_reg;              // R1
            alarm_irq    <= flag_reg & irqen_reg; // R2 R12
            irq          <= |(ists_next & imask_reg);
        end
    end

endmodule

//--- tod_ref_src.sv
// Free-running stand-in for the slow reference oscillator
`timescale 1ns/1ps
module tod_ref_src
#(
    parameter HALF = 4
)
(
    input  wire sys_clk,
    output reg  ref_clk
);
    integer cnt = 0;
    initial ref_clk = 1'b0;
    // Far faster than the real part: a fraction step every 1024 cycles
    always @(posedge sys_clk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            ref_clk <= ~ref_clk;
    end
endmodule

//--- tod_props.sv
// Port-level checks of the time-of-day block
`timescale 1ns/1ps
`include "tod_defs.vh"
module tod_props
(
    input logic        sys_clk,
    input logic        rstn,
    input logic        ce,
    input logic [31:0] addr,
    input logic [31:0] wr_data,
    input logic        wr_en,
    input logic        rd_en,
    input logic [31:0] rd_data,
    input logic        alarm_match,
    input logic        alarm_active,
    input logic        alarm_irq,
    input logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire ws = ce && wr_en && addr == `TOD_ADDR_SECONDS;
    wire rs = ce && rd_en && addr == `TOD_ADDR_SECONDS;
    wire rf = ce && rd_en && addr == `TOD_ADDR_FRACTION;
    wire wc = ce && wr_en && addr == `TOD_ADDR_CTRL;
    wire wm = ce && wr_en && addr == `TOD_ADDR_INT_MASK;
    wire wa = ce && wr_en && addr == `TOD_ADDR_FRAC_ALARM;
    wire ru = ce && rd_en && (addr < `TOD_ADDR_CTRL || addr > `TOD_ADDR_INT_MASK);
    rd_idle_a: assert property (ce && !rd_en |=> rd_data == 32'h0)
        else $error("read data not idle");
    sec_load_a: assert property (ws ##2 rs |=> rd_data == $past(wr_data, 3))
        else $error("seconds not loaded");
    frac_clear_a: assert property (ws ##2 rs ##2 rf |=> rd_data == 32'h0)
        else $error("fraction not cleared");
    unmapped_rd_a: assert property (ru |=> rd_data == 32'h0)
        else $error("unmapped read not zero");
    alarm_gate_a: assert property (wc |-> ##2 alarm_active == $past(wr_data[2], 2))
        else $error("alarm power gate wrong");
    irq_block_a: assert property (wc && !wr_data[1] |-> ##2 !alarm_irq)
        else $error("alarm irq not blocked");
    flag_clear_a: assert property (wa && !alarm_match |-> ##2 !alarm_irq)
        else $error("alarm flag not cleared");
    mask_off_a: assert property (wm && wr_data[1:0] == 2'h0 |-> ##2 !irq)
        else $error("masked irq high");
endmodule

//--- tb_time_of_day_seconds_alarm.sv
// Self-checking bench of the time-of-day block
`timescale 1ns/1ps
`include "tod_defs.vh"
module tb_time_of_day_seconds_alarm;
    logic        sys_clk = 0;
    logic        rstn = 0;
    logic        ce = 1;
    logic [31:0] addr = 0;
    logic [31:0] wr_data = 0;
    logic        wr_en = 0;
    logic        rd_en = 0;
    logic        alarm_match = 0;
    logic [31:0] d;
    wire  [31:0] rd_data;
    wire         ref_clk;
    wire         alarm_active;
    wire         alarm_irq;
    wire         irq;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;

    tod_top DUT (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .slow_reference_clock(ref_clk),
        .alarm_match(alarm_match), .alarm_active(alarm_active), .alarm_irq(alarm_irq),
        .irq(irq));
    tod_ref_src u_ref (.sys_clk(sys_clk), .ref_clk(ref_clk));

    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input [31:0] got, input [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // Full-word accesses only
    task automatic wr(input [31:0] a, input [31:0] v);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input [31:0] a, input [31:0] exp, input string m);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1;
        d = rd_data;
        chk(d, exp, m);
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse_match;
        @(posedge sys_clk);
        alarm_match <= 1'b1;
        @(posedge sys_clk);
        alarm_match <= 1'b0;
        waitc(4);
    endtask

    task automatic t_seconds;
        wr(`TOD_ADDR_SECONDS, 32'hFFFFFFFF);
        rchk(`TOD_ADDR_SECONDS, 32'hFFFFFFFF, "sec load");
        rchk(`TOD_ADDR_FRACTION, 32'h0, "frac clear");
        wr(`TOD_ADDR_FRACTION, 32'h0);
        waitc(1100);
        rchk(`TOD_ADDR_SECONDS, 32'h0, "sec wrap");
        waitc(1100);
        rchk(`TOD_ADDR_FRACTION, 32'h0, "frac held");
        rchk(`TOD_ADDR_SECONDS, 32'h0, "sec steady");
        rchk(`TOD_ADDR_FRACTION, 32'h1, "frac snap");
        rchk(`TOD_ADDR_INT_STATUS, 32'h1, "tick status");
        chk(irq, 1'b0, "tick masked");
        wr(`TOD_ADDR_INT_MASK, 32'h1);
        waitc(2);
        chk(irq, 1'b1, "tick irq");
        wr(`TOD_ADDR_INT_STATUS, 32'h1);
        waitc(2);
        chk(irq, 1'b0, "tick w1c");
        $display("test seconds done");
    endtask

    task automatic t_hold;
        wr(`TOD_ADDR_CTRL, 32'h6);
        wr(`TOD_ADDR_INT_MASK, 32'h3);
        wr(`TOD_ADDR_SECONDS, 32'h12345678);
        rstn <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        rchk(`TOD_ADDR_SECONDS, 32'h12345678, "sec kept");
        rchk(`TOD_ADDR_CTRL, 32'h0, "ctrl rst");
        rchk(`TOD_ADDR_INT_MASK, 32'h0, "mask rst");
        rchk(`TOD_ADDR_INT_STATUS, 32'h0, "status rst");
        chk({alarm_active, alarm_irq, irq}, 3'h0, "outs rst");
        $display("test hold done");
    endtask

    task automatic t_alarm;
        wr(`TOD_ADDR_CTRL, 32'h7);
        rchk(`TOD_ADDR_CTRL, 32'h6, "flag ro");
        chk(alarm_active, 1'b1, "alarm on");
        pulse_match;
        rchk(`TOD_ADDR_CTRL, 32'h7, "flag set");
        chk(alarm_irq, 1'b1, "alarm irq");
        rchk(`TOD_ADDR_INT_STATUS, 32'h2, "alarm status");
        wr(`TOD_ADDR_INT_MASK, 32'h2);
        waitc(2);
        chk(irq, 1'b1, "irq alarm");
        wr(`TOD_ADDR_INT_MASK, 32'h0);
        waitc(2);
        chk(irq, 1'b0, "irq masked");
        wr(`TOD_ADDR_INT_MASK, 32'h2);
        waitc(2);
        chk(irq, 1'b1, "irq unmasked");
        wr(`TOD_ADDR_CTRL, 32'h4);
        waitc(2);
        chk(alarm_irq, 1'b0, "irq gated");
        wr(`TOD_ADDR_CTRL, 32'h6);
        waitc(2);
        chk(alarm_irq, 1'b1, "irq open");
        wr(`TOD_ADDR_FRAC_ALARM, 32'h0);
        waitc(2);
        chk(alarm_irq, 1'b0, "flag clear");
        wr(`TOD_ADDR_INT_STATUS, 32'h2);
        waitc(2);
        chk(irq, 1'b0, "alarm w1c");
        wr(`TOD_ADDR_CTRL, 32'h2);
        pulse_match;
        rchk(`TOD_ADDR_CTRL, 32'h2, "alarm off");
        chk(alarm_active, 1'b0, "gate off");
        $display("test alarm done");
    endtask

    task automatic t_unmapped;
        wr(32'h10001000, 32'hFFFFFFFF);
        rchk(32'h10001000, 32'h0, "unmapped");
        $display("test unmapped done");
    endtask

    // With the enable low a seconds write must be ignored
    task automatic t_freeze;
        wr(`TOD_ADDR_SECONDS, 32'h0000A5A5);
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(`TOD_ADDR_SECONDS, 32'h00005A5A);
        @(posedge sys_clk);
        ce <= 1'b1;
        rchk(`TOD_ADDR_SECONDS, 32'h0000A5A5, "ce freeze");
        rchk(`TOD_ADDR_FRACTION, 32'h0, "ce frac");
        $display("test freeze done");
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            final_report;
        end
    end

    initial
    begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        wr(`TOD_ADDR_SECONDS, 32'h0);
        wr(`TOD_ADDR_INT_STATUS, 32'h3);
        t_unmapped;
        t_seconds;
        t_hold;
        t_alarm;
        t_freeze;
        final_report;
    end
endmodule

bind tod_top tod_props u_props (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .alarm_match(alarm_match), .alarm_active(alarm_active), .alarm_irq(alarm_irq), .irq(irq));
